/* rtl/sam_pkg.sv */
// package: constants and carriers for string addressing and arithmetic modes
// Contract
// - byte run fills consecutive accumulators ascending
// - word run fills accumulators from even addresses
// - word access ignores address bit zero
// - byte run post-increment advances pointer by one
// - word run post-increment advances pointer by two
// - mark set and clear address by word index
// - byte-address mark set equals index half
// - word read copies mark into status tag
// - byte read updates tag, pair shares mark
// - run read takes tag from last word
// - element count is length register plus two
// - four mode bits at status bits zero-three
// - mode bits set by write or op
// - unsigned load op sets unsigned bit
// - sign extend copies bit 16 to 17; multiplier takes both bits 16 and 17 from bit 15 (code fills bits 16 and 17 of both operands from bit 15)
// - unsigned bit selects unsigned multiply
// - saturation clamps to extreme on overflow
// - run saturation forces only top word
// - overflow always sets flag, unclamped otherwise
// - fraction mode shifts multiplier left one
// - byte load zero-fills upper eight bits
package sam_pkg;
  // ----------------------------------------
  // sizes and bit positions
  // ----------------------------------------
  localparam int          ACC_COUNT     = 16;
  localparam int          ACC_AW        = 4;
  localparam int          ADDR_W        = 16;
  localparam int          WORD_W        = 16;
  localparam int          RUN_OFFSET    = 2;
  localparam int          ST_SIGN_POS   = 0;
  localparam int          ST_UNS_POS    = 1;
  localparam int          ST_SAT_POS    = 2;
  localparam int          ST_FRAC_POS   = 3;
  localparam int          ST_OVF_POS    = 4;
  localparam int          ST_TAG_POS    = 5;
  localparam logic [15:0] WORD_MAX_POS  = 16'h7fff;
  localparam logic [15:0] WORD_MAX_NEG  = 16'h8000;
  localparam logic [5:0]  STATUS_RESET  = 6'h00;
  localparam logic [15:0] BYTE_STEP     = 16'h0001;
  localparam logic [15:0] WORD_STEP     = 16'h0002;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  typedef enum logic [4:0] {
    SAM_NOP              = 5'h00,
    SAM_BYTE_LOAD        = 5'h01,
    SAM_WORD_LOAD        = 5'h02,
    SAM_BYTE_RUN_LOAD    = 5'h03,
    SAM_WORD_RUN_LOAD    = 5'h04,
    SAM_MARK_SET         = 5'h05,
    SAM_MARK_CLEAR       = 5'h06,
    SAM_MARK_SET_BYTE    = 5'h07,
    SAM_SIGN_EXT_ON      = 5'h08,
    SAM_SIGN_EXT_OFF     = 5'h09,
    SAM_SATURATE_ON      = 5'h0a,
    SAM_SATURATE_OFF     = 5'h0b,
    SAM_FRAC_ON          = 5'h0c,
    SAM_FRAC_OFF         = 5'h0d,
    SAM_UNS_MULT_LOAD    = 5'h0e,
    SAM_ADD              = 5'h0f,
    SAM_ADD_RUN          = 5'h10,
    SAM_MULT             = 5'h11,
    SAM_STATUS_WRITE     = 5'h12
  } sam_cmd_e;

  typedef enum logic [2:0] {
    SAM_IDLE  = 3'b000,
    SAM_FETCH = 3'b001,
    SAM_WAIT  = 3'b011,
    SAM_MARK  = 3'b010,
    SAM_ADDW  = 3'b110
  } sam_state_e;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic              valid;
    sam_cmd_e          cmd;
    logic [ADDR_W-1:0] addr;
    logic              use_index;
    logic              post_inc;
    logic [ACC_AW-1:0] src_acc;
    logic [WORD_W-1:0] data;
  } sam_req_s;

  typedef struct packed {
    logic              rd;
    logic              mark_wr;
    logic              mark_val;
    logic [ADDR_W-1:0] addr;
  } sam_mem_s;
endpackage

/* rtl/sam_acc_bank.sv */
// accumulator bank: two registered read ports, one write port
`timescale 1ns/100ps
module sam_acc_bank
  import sam_pkg::*;
#(
  parameter int DEPTH = ACC_COUNT,
  parameter int AW    = ACC_AW,
  parameter int W     = WORD_W
) (
  // clock and reset
  input  wire logic         clock_in,
  input  wire logic         rstn_in,
  // write
  input  wire logic         wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [W-1:0]  wr_data_in,
  // reads
  input  wire logic [AW-1:0] rd_a_addr_in,
  input  wire logic [AW-1:0] rd_b_addr_in,
  output logic      [W-1:0]  rd_a_out,
  output logic      [W-1:0]  rd_b_out
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0]            ra;
    logic [W-1:0]            rb;
  } sam_bank_s;
  sam_bank_s st_reg, st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.ra = st_reg.mem[rd_a_addr_in];
    st_next.rb = st_reg.mem[rd_b_addr_in];
    if (wr_en_in) begin
      st_next.mem[wr_addr_in] = wr_data_in;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_a_out = st_reg.ra;
  assign rd_b_out = st_reg.rb;
endmodule // sam_acc_bank

/* rtl/sam_mult.sv */
// multiplier with operand shaping for the mode bits
`timescale 1ns/100ps
module sam_mult
  import sam_pkg::*;
(
  // operands and modes
  input  wire logic [15:0] mcand_in,
  input  wire logic [15:0] mplier_in,
  input  wire logic        sign_ext_in,
  input  wire logic        unsigned_in,
  input  wire logic        frac_in,
  // product
  output logic      [31:0] product_out
);
  logic [17:0] cand_x;
  logic [17:0] plier_x;
  logic [35:0] prod_full;

  always_comb begin
    // bits 16 and 17 from bit 15 only with sign extension on and unsigned bit clear
    cand_x  = {((sign_ext_in && !unsigned_in) ? {2{mcand_in[15]}} : 2'b00),
               mcand_in};
    plier_x = {((sign_ext_in && !unsigned_in) ? {2{mplier_in[15]}} : 2'b00),
               mplier_in};
    if (frac_in) begin
      plier_x = {plier_x[16:0], 1'b0};
    end
    prod_full = $signed(cand_x) * $signed(plier_x);
  end

  assign product_out = prod_full[31:0];
endmodule // sam_mult

/* rtl/sam_core.sv */
// datapath core: run loads, mark bits, status modes, saturating add, multiply
`timescale 1ns/100ps
module sam_core
  import sam_pkg::*;
(
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              rstn_in,
  // decoder request
  input  wire sam_req_s          req_in,
  output logic                   req_ready_out,
  // control registers seen by software
  input  wire logic              run_len_wr_in,
  input  wire logic [7:0]        run_len_data_in,
  input  wire logic              acc_ptr_wr_in,
  input  wire logic [ACC_AW-1:0] acc_ptr_data_in,
  input  wire logic              index_wr_in,
  input  wire logic [ADDR_W-1:0] index_data_in,
  // data memory
  output sam_mem_s               mem_out,
  input  wire logic [15:0]       mem_rdata_in,
  input  wire logic              mem_rmark_in,
  // state seen outside
  output logic [5:0]             status_out,
  output logic [ADDR_W-1:0]      index_pointer_out,
  output logic [7:0]             run_length_reg_out,
  output logic [ACC_AW-1:0]      acc_window_pointer_out,
  output logic [31:0]            product_out,
  output logic [ACC_AW-1:0]      acc_rd_addr_in_use_out,
  output logic [15:0]            acc_rd_data_out
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    sam_state_e        fsm;
    logic [5:0]        status;
    logic [7:0]        run_len;
    logic [ACC_AW-1:0] acc_ptr;
    logic [ADDR_W-1:0] index;
    logic [ADDR_W-1:0] addr;
    logic [8:0]        left;
    logic [ACC_AW-1:0] dst;
    logic              is_word;
    logic              upd_index;
    logic              is_run;
    logic              carry;
    logic [15:0]       mplier;
    sam_mem_s          mem;
    logic [31:0]       product;
  } sam_core_s;
  sam_core_s st_reg, st_next;

  logic              acc_wr;
  logic [ACC_AW-1:0] acc_wa;
  logic [15:0]       acc_wd;
  logic [ACC_AW-1:0] acc_ra;
  logic [ACC_AW-1:0] acc_rb;
  logic [15:0]       acc_a;
  logic [15:0]       acc_b;
  logic [31:0]       mult_p;
  logic [16:0]       sum;
  logic              ovf;
  logic [ADDR_W-1:0] req_addr;

  sam_acc_bank #(
    .DEPTH (ACC_COUNT),
    .AW    (ACC_AW),
    .W     (WORD_W)
  ) u_bank (
    .clock_in     (clock_in),
    .rstn_in      (rst_n),
    .wr_en_in     (acc_wr),
    .wr_addr_in   (acc_wa),
    .wr_data_in   (acc_wd),
    .rd_a_addr_in (acc_ra),
    .rd_b_addr_in (acc_rb),
    .rd_a_out     (acc_a),
    .rd_b_out     (acc_b)
  );

  sam_mult u_mult (
    .mcand_in    (acc_a),
    .mplier_in   (st_reg.mplier),
    .sign_ext_in (st_reg.status[ST_SIGN_POS]),
    .unsigned_in (st_reg.status[ST_UNS_POS]),
    .frac_in     (st_reg.status[ST_FRAC_POS]),
    .product_out (mult_p)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next     = st_reg;
    st_next.mem = '0;
    acc_wr      = 1'b0;
    acc_wa      = st_reg.dst;
    acc_wd      = 16'h0000;
    acc_ra      = req_in.src_acc;
    acc_rb      = st_reg.dst;
    sum         = 17'h00000;
    ovf         = 1'b0;
    req_addr    = req_in.use_index ? st_reg.index : req_in.addr;
    if (run_len_wr_in) begin
      st_next.run_len = run_len_data_in;
    end
    if (acc_ptr_wr_in) begin
      st_next.acc_ptr = acc_ptr_data_in;
    end
    if (index_wr_in) begin
      st_next.index = index_data_in;
    end
    case (st_reg.fsm)
      SAM_IDLE: begin
        if (req_in.valid) begin
          acc_rb            = st_reg.acc_ptr;
          st_next.dst       = st_reg.acc_ptr;
          st_next.upd_index = req_in.use_index && req_in.post_inc;
          st_next.is_run    = 1'b0;
          st_next.left      = 9'h000;
          case (req_in.cmd)
            SAM_BYTE_LOAD, SAM_WORD_LOAD, SAM_BYTE_RUN_LOAD, SAM_WORD_RUN_LOAD: begin
              st_next.is_word = (req_in.cmd == SAM_WORD_LOAD) ||
                                (req_in.cmd == SAM_WORD_RUN_LOAD);
              st_next.addr    = st_next.is_word ? {req_addr[ADDR_W-1:1], 1'b0}
                                                : req_addr;
              if ((req_in.cmd == SAM_BYTE_RUN_LOAD) || (req_in.cmd == SAM_WORD_RUN_LOAD)) begin
                st_next.left = {1'b0, st_reg.run_len} + 9'(RUN_OFFSET - 1);
              end
              if (req_in.use_index) begin
                st_next.index = st_next.addr;
              end
              st_next.fsm = SAM_FETCH;
            end
            SAM_MARK_SET, SAM_MARK_CLEAR, SAM_MARK_SET_BYTE: begin
              st_next.mem.mark_wr  = 1'b1;
              st_next.mem.mark_val = (req_in.cmd != SAM_MARK_CLEAR);
              st_next.mem.addr     = (req_in.cmd == SAM_MARK_SET_BYTE)
                                     ? {req_addr[ADDR_W-1:1], 1'b0}
                                     : {req_addr[ADDR_W-2:0], 1'b0};
            end
            SAM_SIGN_EXT_ON:   st_next.status[ST_SIGN_POS] = 1'b1;
            SAM_SIGN_EXT_OFF:  st_next.status[ST_SIGN_POS] = 1'b0;
            SAM_SATURATE_ON:   st_next.status[ST_SAT_POS]  = 1'b1;
            SAM_SATURATE_OFF:  st_next.status[ST_SAT_POS]  = 1'b0;
            SAM_FRAC_ON:       st_next.status[ST_FRAC_POS] = 1'b1;
            SAM_FRAC_OFF:      st_next.status[ST_FRAC_POS] = 1'b0;
            SAM_UNS_MULT_LOAD: begin
              st_next.mplier              = req_in.data;
              st_next.status[ST_UNS_POS]  = 1'b1;
            end
            SAM_STATUS_WRITE:  st_next.status = req_in.data[5:0];
            SAM_MULT: begin
              st_next.fsm = SAM_MARK;
            end
            SAM_ADD, SAM_ADD_RUN: begin
              st_next.mplier = req_in.data;
              st_next.is_run = (req_in.cmd == SAM_ADD_RUN);
              st_next.left   = st_next.is_run ? {1'b0, st_reg.run_len} + 9'(RUN_OFFSET - 1)
                                              : 9'h000;
              st_next.carry  = 1'b0;
              st_next.fsm    = SAM_ADDW;
            end
            default: st_next.fsm = SAM_IDLE;
          endcase
        end
      end
      SAM_FETCH: begin
        st_next.mem.rd   = 1'b1;
        st_next.mem.addr = st_reg.addr;
        st_next.fsm      = SAM_WAIT;
      end
      SAM_WAIT: begin
        acc_wr = 1'b1;
        acc_wd = st_reg.is_word ? mem_rdata_in
                 : {8'h00, (st_reg.addr[0] ? mem_rdata_in[7:0] : mem_rdata_in[15:8])};
        st_next.status[ST_TAG_POS] = mem_rmark_in;
        st_next.addr = st_reg.addr + (st_reg.is_word ? WORD_STEP : BYTE_STEP);
        if (st_reg.upd_index) begin
          st_next.index = st_next.addr;
        end
        st_next.dst = st_reg.dst + 1'b1;
        if (st_reg.left == 9'h000) begin
          st_next.fsm = SAM_IDLE;
        end else begin
          st_next.left = st_reg.left - 9'h001;
          st_next.fsm  = SAM_FETCH;
        end
      end
      SAM_MARK: begin
        st_next.product = mult_p;
        st_next.fsm     = SAM_IDLE;
      end
      SAM_ADDW: begin
        sum    = {1'b0, acc_b} + {1'b0, st_reg.mplier} + {16'h0000, st_reg.carry};
        acc_wr = 1'b1;
        acc_wd = sum[15:0];
        st_next.carry = sum[16];
        st_next.dst   = st_reg.dst + 1'b1;
        acc_rb        = st_reg.dst + 1'b1;
        if (st_reg.left == 9'h000) begin
          ovf = (acc_b[15] == st_reg.mplier[15]) && (sum[15] != acc_b[15]);
          if (ovf) begin
            st_next.status[ST_OVF_POS] = 1'b1;
            if (st_reg.status[ST_SAT_POS]) begin
              acc_wd = acc_b[15] ? WORD_MAX_NEG : WORD_MAX_POS;
            end
          end
          st_next.fsm = SAM_IDLE;
        end else begin
          st_next.left = st_reg.left - 9'h001;
          st_next.fsm  = SAM_ADDW;
        end
      end
      default: st_next.fsm = SAM_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      st_reg        <= '0;
      st_reg.status <= STATUS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign req_ready_out          = (st_reg.fsm == SAM_IDLE);
  assign mem_out                = st_reg.mem;
  assign status_out             = st_reg.status;
  assign index_pointer_out      = st_reg.index;
  assign run_length_reg_out     = st_reg.run_len;
  assign acc_window_pointer_out = st_reg.acc_ptr;
  assign product_out            = st_reg.product;
  assign acc_rd_addr_in_use_out = st_reg.dst;
  assign acc_rd_data_out        = acc_b;
endmodule // sam_core

/* tb/sam_core_monitor.sv */
// checker: port properties of the datapath core
`timescale 1ns/100ps
module sam_core_monitor
  import sam_pkg::*;
(
  // clock and reset
  input wire logic              clock_in,
  input wire logic              rstn_in,
  // watched ports
  input wire sam_req_s          req_in,
  input wire logic              req_ready_out,
  input wire sam_mem_s          mem_out,
  input wire logic              mem_rmark_in,
  input wire logic [5:0]        status_out,
  input wire logic [ADDR_W-1:0] index_pointer_out,
  input wire logic [7:0]        run_length_reg_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // ----
  // helpers
  // ----
  logic              take;
  logic              run;
  sam_cmd_e          cmd_reg;
  logic              pinc_reg;
  logic              mark_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] idx_reg;
  logic [8:0]        rds_reg;
  assign take = req_in.valid && req_ready_out;
  assign run  = cmd_reg inside {SAM_BYTE_RUN_LOAD, SAM_WORD_RUN_LOAD};
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_reg  <= SAM_NOP;
      pinc_reg <= 1'b0;
      mark_reg <= 1'b0;
      addr_reg <= '0;
      idx_reg  <= '0;
      rds_reg  <= '0;
    end else begin
      if (mem_out.rd) mark_reg <= mem_rmark_in;
      if (take) begin
        cmd_reg  <= req_in.cmd;
        pinc_reg <= req_in.use_index && req_in.post_inc;
        addr_reg <= req_in.addr;
        idx_reg  <= index_pointer_out;
        rds_reg  <= '0;
      end else if (mem_out.rd) begin
        rds_reg <= rds_reg + 9'h001;
      end
    end
  end
  // ----
  // properties
  // ----
  property p_mark_addr; mem_out.mark_wr |-> mem_out.mark_val == (cmd_reg != SAM_MARK_CLEAR) &&
    mem_out.addr == {(cmd_reg == SAM_MARK_SET_BYTE ? addr_reg[15:1] : addr_reg[14:0]), 1'b0};
  endproperty
  a_mark_addr: assert property (p_mark_addr) else $error("mark address wrong");
  property p_word_even; mem_out.rd && cmd_reg inside {SAM_WORD_LOAD, SAM_WORD_RUN_LOAD}
    |-> !mem_out.addr[0]; endproperty
  a_word_even: assert property (p_word_even) else $error("odd word address");
  property p_sign_on; take && req_in.cmd == SAM_SIGN_EXT_ON
    |=> status_out[ST_SIGN_POS]; endproperty
  a_sign_on: assert property (p_sign_on) else $error("sign bit not set");
  property p_frac_off; take && req_in.cmd == SAM_FRAC_OFF
    |=> !status_out[ST_FRAC_POS]; endproperty
  a_frac_off: assert property (p_frac_off) else $error("fraction bit not clear");
  property p_uns_set; take && req_in.cmd == SAM_UNS_MULT_LOAD
    |=> status_out[ST_UNS_POS]; endproperty
  a_uns_set: assert property (p_uns_set) else $error("unsigned bit not set");
  property p_uns_cause; $rose(status_out[ST_UNS_POS]) |-> $past(take) &&
    $past(req_in.cmd) inside {SAM_UNS_MULT_LOAD, SAM_STATUS_WRITE}; endproperty
  a_uns_cause: assert property (p_uns_cause) else $error("unsigned bit rose alone");
  property p_run_count; $rose(req_ready_out) && run
    |-> rds_reg == {1'b0, run_length_reg_out} + 9'h002; endproperty
  a_run_count: assert property (p_run_count) else $error("run fetch count");
  property p_idx_step; $rose(req_ready_out) && run && pinc_reg |-> index_pointer_out == idx_reg +
    (cmd_reg == SAM_BYTE_RUN_LOAD ? 16'h0001 : 16'h0002) * (16'(run_length_reg_out) + 16'h0002);
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("index step");
  property p_tag_last; $rose(req_ready_out) && (run || cmd_reg inside {SAM_BYTE_LOAD,
    SAM_WORD_LOAD}) |-> status_out[ST_TAG_POS] == mark_reg; endproperty
  a_tag_last: assert property (p_tag_last) else $error("tag not last mark");
endmodule // sam_core_monitor

/* tb/sam_mem_model.sv */
// partner: data memory, one word and one mark per byte pair
`timescale 1ns/100ps
module sam_mem_model
  import sam_pkg::*;
(
  // clock
  input  wire logic     clock_in,
  // memory port of the core
  input  wire sam_mem_s mem_in,
  output logic [15:0]   rdata_out,
  output logic          rmark_out
);
  logic [15:0] word_mem [256];
  logic        mark_mem [256];
  logic [15:0] tab [16] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'h1122, 16'h3344,
    16'h0000, 16'h0000, 16'h7ffe, 16'h8002, 16'h0000, 16'hffff, 16'h7fff, 16'h8000,
    16'h7fff, 16'h0080};
  logic [7:0]  wa;
  assign wa = mem_in.addr[8:1];
  initial begin
    for (int i = 0; i < 256; i++) begin
      word_mem[i] = 16'(i);
      if (i < 16) word_mem[i] = tab[i];
      mark_mem[i] = 1'b0;
    end
  end
  // answer while the read strobe stands, inverted lines otherwise
  assign rdata_out = mem_in.rd ? word_mem[wa] : ~word_mem[wa];
  assign rmark_out = mem_in.rd ? mark_mem[wa] : ~mark_mem[wa];
  always @(posedge clock_in) begin
    if (mem_in.mark_wr) mark_mem[wa] <= mem_in.mark_val;
  end
endmodule // sam_mem_model

/* tb/test_string_addressing_and_arith_modes.sv */
// testbench: run loads, marks, mode bits, saturation and multiply
`timescale 1ns/100ps
module test_string_addressing_and_arith_modes
  import sam_pkg::*;
;
  logic        clock_in;
  logic        rstn_in;
  sam_req_s    req;
  logic        ready;
  logic        len_wr;
  logic        ptr_wr;
  logic        idx_wr;
  logic [7:0]  len_d;
  logic [3:0]  ptr_d;
  logic [15:0] idx_d;
  sam_mem_s    mem;
  logic [15:0] rdata;
  logic        rmark;
  logic [5:0]  status;
  logic [15:0] idx;
  logic [31:0] product;
  logic [15:0] acc;
  logic [3:0]  dst;
  int          failures;
  int          check_count;
  int          cycles = 0;
  logic [15:0] run_exp [16] = '{16'h0078, 16'h009a, 16'h00bc, 16'h00de, 16'h5678, 16'h9abc,
    16'hdef0, 16'h1122, 16'h00bc, 16'h00de, 16'h00f0, 16'h0011, 16'h5678, 16'h9abc,
    16'hdef0, 16'h1122};
  sam_cmd_e    mode_op [9] = '{SAM_STATUS_WRITE, SAM_SIGN_EXT_ON, SAM_SATURATE_ON, SAM_FRAC_ON,
    SAM_SIGN_EXT_OFF, SAM_SATURATE_OFF, SAM_FRAC_OFF, SAM_STATUS_WRITE, SAM_STATUS_WRITE};
  logic [3:0]  mode_exp [9] = '{4'h0, 4'h1, 4'h5, 4'hd, 4'hc, 4'h8, 4'h0, 4'hf, 4'h0};
  logic [15:0] sat_tab [12] = '{16'h0010, 16'h0005, 16'h7fff, 16'h0010, 16'h0005, 16'h8003,
    16'h0012, 16'hfff0, 16'h8000, 16'h0012, 16'hfff0, 16'h7ff2};

  sam_core sam_core_inst (.clock_in(clock_in), .rstn_in(rstn_in), .req_in(req),
    .req_ready_out(ready), .run_len_wr_in(len_wr), .run_len_data_in(len_d),
    .acc_ptr_wr_in(ptr_wr), .acc_ptr_data_in(ptr_d), .index_wr_in(idx_wr),
    .index_data_in(idx_d), .mem_out(mem), .mem_rdata_in(rdata), .mem_rmark_in(rmark),
    .status_out(status), .index_pointer_out(idx), .run_length_reg_out(),
    .acc_window_pointer_out(), .product_out(product), .acc_rd_addr_in_use_out(dst),
    .acc_rd_data_out(acc));
  sam_mem_model sam_mem_model_inst (.clock_in(clock_in), .mem_in(mem), .rdata_out(rdata),
    .rmark_out(rmark));

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  // ----
  // tasks
  // ----
  task automatic conclude();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    @(negedge clock_in);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
    @(posedge clock_in);
  endtask
  task automatic issue(input sam_cmd_e c, input logic [15:0] a, input logic ui,
                       input logic [3:0] s, input logic [15:0] d);
    int n;
    n = 0;
    req <= '{1'b1, c, a, ui, ui, s, d};
    do @(negedge clock_in); while (!ready && ++n < 400);
    @(posedge clock_in);
    req.valid <= 1'b0;
    do @(negedge clock_in); while (!ready && ++n < 400);
    @(posedge clock_in);
    if (n >= 400) failures++;
  endtask
  task automatic setregs(input logic [7:0] l, input logic [3:0] p, input logic [15:0] x);
    {len_wr, ptr_wr, idx_wr} <= 3'b111;
    len_d <= l;
    ptr_d <= p;
    idx_d <= x;
    @(posedge clock_in);
    {len_wr, ptr_wr, idx_wr} <= 3'b000;
    @(posedge clock_in);
  endtask
  task automatic acc_is(input logic [3:0] p, input logic [15:0] e);
    ptr_wr <= 1'b1;
    ptr_d  <= p;
    @(posedge clock_in);
    ptr_wr <= 1'b0;
    issue(SAM_NOP, 16'h0000, 1'b0, 4'h0, 16'h0000);
    @(negedge clock_in);
    check("dst", 32'(dst), 32'(p));
    check("acc", 32'(acc), 32'(e));
  endtask

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  // ----
  // tests
  // ----
  initial begin
    rstn_in = 1'b0;
    req = '0;
    {len_wr, ptr_wr, idx_wr} = 3'b000;
    len_d = 8'h00;
    ptr_d = 4'h0;
    idx_d = 16'h0000;
    failures = 0;
    check_count = 0;
    repeat (4) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    for (int t = 0; t < 4; t++) begin
      setregs(8'h02, 4'h2, t == 2 ? 16'h0005 : 16'h0002);
      issue(t[0] ? SAM_WORD_RUN_LOAD : SAM_BYTE_RUN_LOAD, t < 2 ? 16'h0003 : 16'h0000,
            t >= 2, 4'h0, 16'h0000);
      for (int k = 0; k < 4; k++) acc_is(4'(k + 2), run_exp[t * 4 + k]);
      check("index", 32'(idx), t == 2 ? 32'h9 : t == 3 ? 32'ha : 32'h2);
      $display("run case %0d done", t);
    end
    setregs(8'h00, 4'h1, 16'h0000);
    issue(SAM_MARK_SET, 16'h0003, 1'b0, 4'h0, 16'h0000);
    issue(SAM_WORD_LOAD, 16'h0006, 1'b0, 4'h0, 16'h0000);
    check("tag", 32'(status[ST_TAG_POS]), 32'h1);
    issue(SAM_MARK_CLEAR, 16'h0003, 1'b0, 4'h0, 16'h0000);
    issue(SAM_WORD_LOAD, 16'h0007, 1'b0, 4'h0, 16'h0000);
    check("tag", 32'(status[ST_TAG_POS]), 32'h0);
    acc_is(4'h1, 16'hdef0);
    issue(SAM_MARK_SET_BYTE, 16'h000a, 1'b0, 4'h0, 16'h0000);
    issue(SAM_BYTE_LOAD, 16'h000b, 1'b0, 4'h0, 16'h0000);
    check("tag", 32'(status[ST_TAG_POS]), 32'h1);
    acc_is(4'h1, 16'h0044);
    for (int k = 0; k < 2; k++) begin
      issue(k ? SAM_MARK_CLEAR : SAM_MARK_SET, 16'h0032, 1'b0, 4'h0, 16'h0000);
      issue(k ? SAM_MARK_SET : SAM_MARK_CLEAR, 16'h0031, 1'b0, 4'h0, 16'h0000);
      issue(SAM_WORD_RUN_LOAD, 16'h0062, 1'b0, 4'h0, 16'h0000);
      check("run tag", 32'(status[ST_TAG_POS]), 32'(k == 0));
    end
    $display("mark tests done");
    for (int m = 0; m < 9; m++) begin
      issue(mode_op[m], 16'h0000, 1'b0, 4'h0, 16'(mode_exp[m]));
      check("modes", 32'(status[3:0]), 32'(mode_exp[m]));
    end
    $display("mode tests done");
    for (int k = 0; k < 4; k++) begin
      issue(SAM_STATUS_WRITE, 16'h0000, 1'b0, 4'h0, k[0] ? 16'h0000 : 16'h0004);
      issue(SAM_WORD_LOAD, sat_tab[3 * k], 1'b0, 4'h1, 16'h0000);
      issue(SAM_ADD, 16'h0000, 1'b0, 4'h1, sat_tab[3 * k + 1]);
      check("overflow", 32'(status[ST_OVF_POS]), 32'h1);
      acc_is(4'h1, sat_tab[3 * k + 2]);
    end
    setregs(8'h00, 4'h0, 16'h0000);
    issue(SAM_STATUS_WRITE, 16'h0000, 1'b0, 4'h0, 16'h0004);
    issue(SAM_WORD_RUN_LOAD, 16'h0016, 1'b0, 4'h0, 16'h0000);
    issue(SAM_ADD_RUN, 16'h0000, 1'b0, 4'h0, 16'h0001);
    acc_is(4'h0, 16'h0000);
    acc_is(4'h1, 16'h7fff);
    $display("saturation tests done");
    setregs(8'h00, 4'h3, 16'h0000);
    issue(SAM_UNS_MULT_LOAD, 16'h0000, 1'b0, 4'h3, 16'h8000);
    issue(SAM_STATUS_WRITE, 16'h0000, 1'b0, 4'h0, 16'h0001);
    issue(SAM_WORD_LOAD, 16'h001a, 1'b0, 4'h3, 16'h0000);
    issue(SAM_MULT, 16'h0000, 1'b0, 4'h3, 16'h8000);
    check("product", product, 32'h40000000);
    issue(SAM_WORD_LOAD, 16'h001c, 1'b0, 4'h3, 16'h0000);
    issue(SAM_UNS_MULT_LOAD, 16'h0000, 1'b0, 4'h3, 16'h7fff);
    issue(SAM_STATUS_WRITE, 16'h0000, 1'b0, 4'h3, 16'h0001);
    issue(SAM_MULT, 16'h0000, 1'b0, 4'h3, 16'h7fff);
    check("product", product, 32'h3fff0001);
    issue(SAM_FRAC_ON, 16'h0000, 1'b0, 4'h3, 16'h0000);
    issue(SAM_MULT, 16'h0000, 1'b0, 4'h3, 16'h7fff);
    check("product", product, 32'h7ffe0002);
    issue(SAM_STATUS_WRITE, 16'h0000, 1'b0, 4'h3, 16'h0000);
    issue(SAM_UNS_MULT_LOAD, 16'h0000, 1'b0, 4'h3, 16'h8000);
    check("unsigned", 32'(status[ST_UNS_POS]), 32'h1);
    issue(SAM_WORD_LOAD, 16'h001e, 1'b0, 4'h3, 16'h0000);
    issue(SAM_MULT, 16'h0000, 1'b0, 4'h3, 16'h8000);
    check("product", product, 32'h00400000);
    $display("multiply tests done");
    conclude();
  end
endmodule // test_string_addressing_and_arith_modes

bind sam_core sam_core_monitor sam_core_monitor_inst (.clock_in(clock_in), .rstn_in(rstn_in),
  .req_in(req_in), .req_ready_out(req_ready_out), .mem_out(mem_out),
  .mem_rmark_in(mem_rmark_in), .status_out(status_out),
  .index_pointer_out(index_pointer_out), .run_length_reg_out(run_length_reg_out));
